// *** hw/rtcwd_core.sv ***
// Contract
// - Unused time bits and alarm-day bits read zero.
// - Oscillator runs only while month bit7 zero.
// - Month bit6 zero drives 1024 Hz square wave.
// - Hours bit6 selects 12-hour; bit5 PM/tens.
// - External hundredths refreshed each tick, whole time at hundredths rollover, unless frozen/stopped.
// - Internal counters keep advancing while externals frozen.
// - Alarm mask bits; all clear needs full match.
// - Masks give daily, hourly, per-minute alarms.
// - Alarm register access clears alarm flag, interrupt.
// - Watchdog registers read back programmed BCD period.
// - Watchdog access reloads countdown, clears flag, interrupt.
// - Countdown zero raises interrupt, reloads, repeats.
// - Zero watchdog period disables watchdog alarms.
// - Command bit7 gates internal-to-external transfers.
// - Command bit6 routes alarms to interrupt pins.
// - Command bit5 picks interrupt B source or sink.
// - Command bit4 selects level or 3 ms pulse.
// - Command bits3,2 suppress watchdog, time-of-day interrupts.
// - Flags set on alarm, clear on access.
// - Read presents addressed byte while selected, output enabled.
// - Write spans select and strobe, captured at end.
// - Fixed map of time, alarm, command registers.
`timescale 1ns/1ps
module rtcwd_core #(
  parameter int TICK_CYC = rtcwd_pkg::TICK_CYC, // Cycles per hundredth tick.
  parameter int WAVE_HALF_CYC = rtcwd_pkg::WAVE_HALF_CYC, // Cycles per square-wave half period.
  parameter int PULSE_CYC = rtcwd_pkg::PULSE_CYC // Cycles per interrupt pulse.
) (
  input wire logic clk_i, // System clock.
  input wire logic rst_b_i, // Asynchronous reset, active low.
  input wire logic chip_sel_b_i, // Chip select, active low.
  input wire logic out_drive_b_i, // Output drive request, active low.
  input wire logic write_strobe_b_i, // Write strobe, active low.
  input wire logic [rtcwd_pkg::ADDR_W-1:0] addr_lines_i, // Address lines.
  input wire logic [7:0] data_lines_i, // Data lines from the host.
  output logic [7:0] data_lines_o, // Data lines to the host.
  output logic data_lines_oe_b_o, // Data drive enable, low while driving.
  output logic irq_out_first_o, // First interrupt pin level when driven.
  output logic irq_out_first_oe_b_o, // First interrupt drive enable, low while driving.
  output logic irq_out_second_o, // Second interrupt pin level when driven.
  output logic irq_out_second_oe_b_o, // Second interrupt drive enable, low while driving.
  output logic square_wave_out_o, // Square wave level.
  output logic square_wave_out_oe_b_o // Square wave drive enable, low while driving.
);

  // Add one to a two-digit BCD value without wrapping.
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Subtract one from a four-digit BCD value.
  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic borrow;
    r = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (r[i*4 +: 4] == 4'h0) begin
          r[i*4 +: 4] = 4'h9;
        end else begin
          r[i*4 +: 4] = r[i*4 +: 4] - 4'h1;
          borrow = 1'b0;
        end
      end
    end
    bcd_dec = r;
  endfunction

  // Last date of a month, with leap years every fourth year.
  function automatic logic [7:0] month_len(input logic [7:0] mon, input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
    if (mon == 8'h02) begin
      month_len = leap ? 8'h29 : 8'h28;
    end else if (mon == 8'h04 || mon == 8'h06 || mon == 8'h09 || mon == 8'h11) begin
      month_len = 8'h30;
    end else begin
      month_len = 8'h31;
    end
  endfunction

  // Store one host byte into a time field; both copies use this.
  function automatic rtcwd_pkg::rtcwd_time_t put_time(input rtcwd_pkg::rtcwd_time_t t, input logic [3:0] a,
                                                     input logic [7:0] d);
    put_time = t;
    case (a)
      rtcwd_pkg::A_HUND: put_time.hund = d;
      rtcwd_pkg::A_SEC: put_time.sec = d & rtcwd_pkg::M_SEC;
      rtcwd_pkg::A_MIN: put_time.min = d & rtcwd_pkg::M_SEC;
      rtcwd_pkg::A_HRS: put_time.hrs = d & rtcwd_pkg::M_HRS;
      rtcwd_pkg::A_DAY: put_time.day = d & rtcwd_pkg::M_DAY;
      rtcwd_pkg::A_DATE: put_time.date = d & rtcwd_pkg::M_DATE;
      rtcwd_pkg::A_MON: put_time.mon = d & rtcwd_pkg::M_MON;
      rtcwd_pkg::A_YR: put_time.yr = d;
      default: put_time = t;
    endcase
  endfunction

  // Bus strobes decoded from the pins.
  wire rd_act = !chip_sel_b_i && !out_drive_b_i && write_strobe_b_i; // Read cycle in progress.
  wire wr_act = !chip_sel_b_i && !write_strobe_b_i; // Write cycle in progress.
  wire in_map = (addr_lines_i[rtcwd_pkg::ADDR_W-1:4] == '0); // Address falls in the register block.
  wire [3:0] rd_addr = addr_lines_i[3:0]; // Register index of a read.

  logic rd_q_r; // Read active last cycle.
  logic wr_q_r; // Write active last cycle.
  logic wr_map_r; // Write address fell in the register block.
  logic [3:0] wr_addr_r; // Address held during a write.
  logic [7:0] wr_data_r; // Data sampled in the last write cycle.
  logic [7:0] cmd_r; // Command register control bits.
  logic osc_stop_r; // Oscillator stopped.
  logic wave_off_r; // Square wave off.
  logic [7:0] amin_r; // Alarm minutes with mask.
  logic [7:0] ahrs_r; // Alarm hours with mask.
  logic [7:0] aday_r; // Alarm day with mask.
  logic [7:0] wdh_r; // Watchdog hundredths.
  logic [7:0] wds_r; // Watchdog seconds.
  logic [15:0] dog_cnt_r; // Live watchdog countdown.
  logic [rtcwd_pkg::CNT_W-1:0] tick_cnt_r; // Hundredth-tick divider.
  logic [rtcwd_pkg::CNT_W-1:0] wave_cnt_r; // Square-wave divider.
  logic wave_r; // Square wave level.
  logic [1:0] flag_r; // Alarm flags: bit 0 time of day, bit 1 watchdog.
  logic [rtcwd_pkg::CNT_W-1:0] pcnt_r [2]; // Pulse time left per flag.
  rtcwd_pkg::rtcwd_time_t int_r; // Internal running counters.
  rtcwd_pkg::rtcwd_time_t ext_r; // External host-visible copy.
  rtcwd_pkg::rtcwd_time_t int_nxt; // Next internal counters.
  rtcwd_pkg::rtcwd_time_t ext_nxt; // Next external copy.
  rtcwd_pkg::rtcwd_time_t adv; // Internal counters after one tick.
  logic sec_wrap; // Seconds roll from 59 to 00 this tick.
  logic [7:0] rd_data; // Selected read byte.

  // Access pulses: a read counts at its start, a write at its end.
  wire rd_start = rd_act && !rd_q_r && in_map; // First cycle of a register read.
  wire wr_end = wr_q_r && !wr_act && wr_map_r; // Write completes this cycle.
  wire [3:0] acc_addr = wr_end ? wr_addr_r : rd_addr; // Address of the access.
  wire acc = rd_start || wr_end; // Any register access this cycle.
  wire alarm_acc = acc && (acc_addr == rtcwd_pkg::A_AMIN || acc_addr == rtcwd_pkg::A_AHRS ||
                           acc_addr == rtcwd_pkg::A_ADAY); // Alarm register touched.
  wire dog_acc = acc && (acc_addr == rtcwd_pkg::A_WDH || acc_addr == rtcwd_pkg::A_WDS); // Watchdog touched.
  wire time_wr = wr_end && wr_addr_r <= rtcwd_pkg::A_YR && wr_addr_r != rtcwd_pkg::A_AMIN &&
                 wr_addr_r != rtcwd_pkg::A_AHRS && wr_addr_r != rtcwd_pkg::A_ADAY; // Time field written.

  // Tick and mode decode.
  wire osc_on = !osc_stop_r; // Oscillator running.
  wire tick = osc_on && (tick_cnt_r == rtcwd_pkg::CNT_W'(TICK_CYC - 1)); // Hundredth-second tick.
  wire freeze_release_bit = cmd_r[rtcwd_pkg::B_FREEZE_RELEASE]; // Transfers enabled.
  wire at_98 = (int_r.hund == 8'h98); // Next tick enters hundredth 99.
  wire at_99 = (int_r.hund == 8'h99); // Next tick rolls hundredths to 00.
  wire hr12 = int_r.hrs[rtcwd_pkg::B_HR12]; // Twelve-hour counting.
  wire [15:0] period = {wds_r, wdh_r}; // Programmed watchdog period.
  wire dog_en = (period != 16'h0000); // Watchdog enabled.
  wire dog_fire = tick && dog_en && !dog_acc && (dog_cnt_r <= 16'h0001); // Countdown reaches zero.
  wire pulse_mode = cmd_r[rtcwd_pkg::B_PULSE]; // Pulse signalling.

  // Alarm compare against the freshly incremented time, masked fields always match.
  wire m_min = amin_r[rtcwd_pkg::B_AMASK] || (adv.min == {1'b0, amin_r[6:0]}); // Minutes match.
  wire m_hrs = ahrs_r[rtcwd_pkg::B_AMASK] || (adv.hrs == {1'b0, ahrs_r[6:0]}); // Hours match.
  wire m_day = aday_r[rtcwd_pkg::B_AMASK] || (adv.day == {5'h00, aday_r[2:0]}); // Day match.
  wire tod_fire = tick && at_98 && sec_wrap && m_min && m_hrs && m_day; // Alarm on the minute boundary.
  wire [1:0] evt = {dog_fire, tod_fire}; // Alarm events per flag.
  wire [1:0] clr = {dog_acc, alarm_acc}; // Clearing accesses per flag.
  wire [1:0] act = flag_r & ~{cmd_r[rtcwd_pkg::B_DOGM], cmd_r[rtcwd_pkg::B_TODM]}; // Unsuppressed.
  wire swap = cmd_r[rtcwd_pkg::B_SWAP]; // Routing select.
  wire irq_a = swap ? act[0] : act[1]; // First pin alarm.
  wire irq_b = swap ? act[1] : act[0]; // Second pin alarm.

  // One tick of the internal counters, carrying digit by digit.
  always_comb begin
    adv = int_r;
    sec_wrap = 1'b0;
    adv.hund = at_99 ? 8'h00 : bcd_inc(int_r.hund);
    if (at_98) begin // Upper fields advance as hundredths enter 99.
      sec_wrap = (int_r.sec == 8'h59);
      adv.sec = sec_wrap ? 8'h00 : bcd_inc(int_r.sec);
      if (sec_wrap) begin
        adv.min = (int_r.min == 8'h59) ? 8'h00 : bcd_inc(int_r.min);
        if (int_r.min == 8'h59) begin
          if (hr12) begin // Twelve-hour counting toggles meridiem at 11 to 12.
            if (int_r.hrs[4:0] == 5'h12) begin
              adv.hrs = {int_r.hrs[7:5], 5'h01};
            end else if (int_r.hrs[4:0] == 5'h11) begin
              adv.hrs = {int_r.hrs[7:6], !int_r.hrs[rtcwd_pkg::B_PM], 5'h12};
            end else begin
              adv.hrs = {int_r.hrs[7:5], 5'(bcd_inc({3'h0, int_r.hrs[4:0]}))};
            end
          end else begin // Twenty-four-hour counting uses bit 5 as a tens digit.
            adv.hrs = (int_r.hrs[5:0] == 6'h23) ? {int_r.hrs[7:6], 6'h00} :
                      {int_r.hrs[7:6], 6'(bcd_inc({2'h0, int_r.hrs[5:0]}))};
          end
          if (hr12 ? (int_r.hrs[5:0] == 6'h31) : (int_r.hrs[5:0] == 6'h23)) begin // Midnight.
            adv.day = (int_r.day == 8'h07) ? rtcwd_pkg::R_ONE : bcd_inc(int_r.day);
            adv.date = (int_r.date == month_len(int_r.mon, int_r.yr)) ? rtcwd_pkg::R_ONE : bcd_inc(int_r.date);
            if (int_r.date == month_len(int_r.mon, int_r.yr)) begin
              adv.mon = (int_r.mon == 8'h12) ? rtcwd_pkg::R_ONE : bcd_inc(int_r.mon);
              if (int_r.mon == 8'h12) begin
                adv.yr = (int_r.yr == 8'h99) ? 8'h00 : bcd_inc(int_r.yr);
              end
            end
          end
        end
      end
    end
  end

  // Next values of both copies; a host write wins over the tick for its field.
  always_comb begin
    int_nxt = tick ? adv : int_r; // Keeps running while frozen.
    ext_nxt = ext_r;
    if (tick && freeze_release_bit) begin // Refresh only when transfers are on.
      ext_nxt.hund = adv.hund;
      if (at_99) begin
        ext_nxt = adv; // Whole copy as hundredths roll to 00.
      end
    end
    if (time_wr) begin
      int_nxt = put_time(int_nxt, wr_addr_r, wr_data_r);
      ext_nxt = put_time(ext_nxt, wr_addr_r, wr_data_r);
    end
  end

  // Register read selection; unused bits read zero.
  always_comb begin
    rd_data = 8'h00;
    if (in_map) begin
      case (rd_addr)
        rtcwd_pkg::A_HUND: rd_data = ext_r.hund;
        rtcwd_pkg::A_SEC: rd_data = ext_r.sec;
        rtcwd_pkg::A_MIN: rd_data = ext_r.min;
        rtcwd_pkg::A_AMIN: rd_data = amin_r;
        rtcwd_pkg::A_HRS: rd_data = ext_r.hrs;
        rtcwd_pkg::A_AHRS: rd_data = ahrs_r;
        rtcwd_pkg::A_DAY: rd_data = ext_r.day;
        rtcwd_pkg::A_ADAY: rd_data = aday_r & rtcwd_pkg::M_ADAY;
        rtcwd_pkg::A_DATE: rd_data = ext_r.date;
        rtcwd_pkg::A_MON: rd_data = {osc_stop_r, wave_off_r, ext_r.mon[5:0]};
        rtcwd_pkg::A_YR: rd_data = ext_r.yr;
        rtcwd_pkg::A_CMD: rd_data = {cmd_r[7:2], flag_r};
        rtcwd_pkg::A_WDH: rd_data = wdh_r;
        rtcwd_pkg::A_WDS: rd_data = wds_r;
        default: rd_data = 8'h00;
      endcase
    end
  end

  // Bus sampling and the data pins.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_q_r <= 1'b0;
      wr_q_r <= 1'b0;
      wr_map_r <= 1'b0;
      wr_addr_r <= 4'h0;
      wr_data_r <= 8'h00;
      data_lines_o <= 8'h00;
      data_lines_oe_b_o <= 1'b1;
    end else begin
      rd_q_r <= rd_act;
      wr_q_r <= wr_act;
      if (wr_act) begin // Latest sample stands when the write ends.
        wr_map_r <= in_map;
        wr_addr_r <= addr_lines_i[3:0];
        wr_data_r <= data_lines_i;
      end
      data_lines_o <= rd_data;
      data_lines_oe_b_o <= !rd_act;
    end
  end

  // Host-written control, alarm and watchdog registers.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cmd_r <= rtcwd_pkg::R_CMD;
      osc_stop_r <= rtcwd_pkg::R_OSC_STOP;
      wave_off_r <= rtcwd_pkg::R_WAVE_OFF;
      amin_r <= 8'h00;
      ahrs_r <= 8'h00;
      aday_r <= 8'h00;
      wdh_r <= 8'h00;
      wds_r <= 8'h00;
    end else if (wr_end) begin
      case (wr_addr_r)
        rtcwd_pkg::A_CMD: cmd_r <= wr_data_r & rtcwd_pkg::M_CMD_RW; // Flags stay read-only.
        rtcwd_pkg::A_MON: begin
          osc_stop_r <= wr_data_r[rtcwd_pkg::B_OSC_STOP];
          wave_off_r <= wr_data_r[rtcwd_pkg::B_WAVE_OFF];
        end
        rtcwd_pkg::A_AMIN: amin_r <= wr_data_r;
        rtcwd_pkg::A_AHRS: ahrs_r <= wr_data_r;
        rtcwd_pkg::A_ADAY: aday_r <= wr_data_r & rtcwd_pkg::M_ADAY;
        rtcwd_pkg::A_WDH: wdh_r <= wr_data_r;
        rtcwd_pkg::A_WDS: wds_r <= wr_data_r;
        default: cmd_r <= cmd_r;
      endcase
    end
  end

  // Time copies, tick divider and watchdog countdown.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_r <= rtcwd_pkg::R_TIME;
      ext_r <= rtcwd_pkg::R_TIME;
      tick_cnt_r <= '0;
      dog_cnt_r <= 16'h0000;
    end else begin
      int_r <= int_nxt;
      ext_r <= ext_nxt;
      tick_cnt_r <= (tick || !osc_on) ? '0 : tick_cnt_r + 1'b1; // Halts with the oscillator.
      if (dog_acc) begin
        dog_cnt_r <= wr_end ? ((wr_addr_r == rtcwd_pkg::A_WDH) ? {wds_r, wr_data_r} : {wr_data_r, wdh_r}) :
                     period; // Reload on any access.
      end else if (dog_fire) begin
        dog_cnt_r <= period; // Repeat every period.
      end else if (tick && dog_en) begin
        dog_cnt_r <= bcd_dec(dog_cnt_r);
      end
    end
  end

  // Flags with optional pulse timing; an alarm wins over a clearing access.
  for (genvar i = 0; i < 2; i++) begin : g_flag
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        flag_r[i] <= 1'b0;
        pcnt_r[i] <= '0;
      end else if (evt[i]) begin
        flag_r[i] <= 1'b1;
        pcnt_r[i] <= rtcwd_pkg::CNT_W'(PULSE_CYC);
      end else if (clr[i]) begin
        flag_r[i] <= 1'b0;
        pcnt_r[i] <= '0;
      end else if (pcnt_r[i] != '0) begin
        pcnt_r[i] <= pcnt_r[i] - 1'b1;
        if (pulse_mode && pcnt_r[i] == rtcwd_pkg::CNT_W'(1)) begin
          flag_r[i] <= 1'b0; // Pulse ends and the pin releases.
        end
      end
    end
  end

  // Square wave and interrupt pins.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wave_cnt_r <= '0;
      wave_r <= 1'b0;
      square_wave_out_o <= 1'b0;
      square_wave_out_oe_b_o <= 1'b1;
      irq_out_first_o <= 1'b0;
      irq_out_first_oe_b_o <= 1'b1;
      irq_out_second_o <= 1'b0;
      irq_out_second_oe_b_o <= 1'b1;
    end else begin
      if (!osc_on || wave_cnt_r == rtcwd_pkg::CNT_W'(WAVE_HALF_CYC - 1)) begin
        wave_cnt_r <= '0;
        wave_r <= osc_on && !wave_r;
      end else begin
        wave_cnt_r <= wave_cnt_r + 1'b1;
      end
      square_wave_out_o <= wave_r;
      square_wave_out_oe_b_o <= wave_off_r; // Released when switched off.
      irq_out_first_o <= 1'b0; // Open drain, pulls low when active.
      irq_out_first_oe_b_o <= !irq_a;
      irq_out_second_o <= cmd_r[rtcwd_pkg::B_BPOL]; // Source high or sink low.
      irq_out_second_oe_b_o <= !irq_b;
    end
  end

endmodule // rtcwd_core

// *** inc/rtcwd_pkg.sv ***
package rtcwd_pkg;
  // Clock rate and the documented times, each with its derived cycle count.
  localparam int CLK_HZ = 125_000_000; // System clock rate in hertz.
  localparam int TICK_US = 10_000; // Hundredth-second tick period in microseconds.
  localparam int TICK_CYC = CLK_HZ / 1_000_000 * TICK_US; // Cycles per hundredth tick.
  localparam int WAVE_HZ = 1024; // Square wave frequency in hertz.
  localparam int WAVE_HALF_CYC = CLK_HZ / (2 * WAVE_HZ); // Cycles per half square-wave period.
  localparam int PULSE_MS = 3; // Least interrupt pulse width in milliseconds.
  localparam int PULSE_CYC = CLK_HZ / 1000 * PULSE_MS; // Cycles per interrupt pulse.
  localparam int CNT_W = 24; // Width of the timing counters.
  localparam int ADDR_W = 17; // Width of the address lines.

  // Register locations.
  localparam logic [3:0] A_HUND = 4'h0; // Hundredths of seconds.
  localparam logic [3:0] A_SEC = 4'h1; // Seconds.
  localparam logic [3:0] A_MIN = 4'h2; // Minutes.
  localparam logic [3:0] A_AMIN = 4'h3; // Alarm minutes.
  localparam logic [3:0] A_HRS = 4'h4; // Hours.
  localparam logic [3:0] A_AHRS = 4'h5; // Alarm hours.
  localparam logic [3:0] A_DAY = 4'h6; // Day of week.
  localparam logic [3:0] A_ADAY = 4'h7; // Alarm day.
  localparam logic [3:0] A_DATE = 4'h8; // Date of month.
  localparam logic [3:0] A_MON = 4'h9; // Month and control bits.
  localparam logic [3:0] A_YR = 4'ha; // Year.
  localparam logic [3:0] A_CMD = 4'hb; // Command register.
  localparam logic [3:0] A_WDH = 4'hc; // Watchdog hundredths.
  localparam logic [3:0] A_WDS = 4'hd; // Watchdog seconds.

  // Readable bits of each register.
  localparam logic [7:0] M_SEC = 8'h7f; // Seconds digits.
  localparam logic [7:0] M_HRS = 8'h7f; // Mode, meridiem and hour digits.
  localparam logic [7:0] M_DAY = 8'h07; // Day of week digit.
  localparam logic [7:0] M_DATE = 8'h3f; // Date digits.
  localparam logic [7:0] M_MON = 8'h1f; // Month digits.
  localparam logic [7:0] M_ADAY = 8'h87; // Alarm day mask and digit.
  localparam logic [7:0] M_CMD_RW = 8'hfc; // Writable command bits.

  // Bit positions.
  localparam int B_OSC_STOP = 7; // Oscillator stop in the months register.
  localparam int B_WAVE_OFF = 6; // Square wave off in the months register.
  localparam int B_HR12 = 6; // Twelve-hour select in the hours register.
  localparam int B_PM = 5; // Meridiem bit in twelve-hour counting.
  localparam int B_AMASK = 7; // Mask bit of each alarm register.
  localparam int B_FREEZE_RELEASE = 7; // Transfer enable.
  localparam int B_SWAP = 6; // Interrupt routing.
  localparam int B_BPOL = 5; // Interrupt B drive polarity.
  localparam int B_PULSE = 4; // Pulse or level select.
  localparam int B_DOGM = 3; // Watchdog interrupt mask.
  localparam int B_TODM = 2; // Time-of-day interrupt mask.

  // Reset values.
  localparam logic [7:0] R_CMD = 8'h8c; // Transfers on, both interrupts suppressed.
  localparam logic [7:0] R_ONE = 8'h01; // First day, date and month.
  localparam logic R_OSC_STOP = 1'b1; // Oscillator stopped.
  localparam logic R_WAVE_OFF = 1'b1; // Square wave off.

  // One full set of time-of-day fields.
  typedef struct packed {
    logic [7:0] hund; // Hundredths.
    logic [7:0] sec; // Seconds.
    logic [7:0] min; // Minutes.
    logic [7:0] hrs; // Hours with mode bits.
    logic [7:0] day; // Day of week.
    logic [7:0] date; // Date of month.
    logic [7:0] mon; // Month digits.
    logic [7:0] yr; // Year.
  } rtcwd_time_t;

  localparam rtcwd_time_t R_TIME = '{8'h00, 8'h00, 8'h00, 8'h00, R_ONE, R_ONE, R_ONE, 8'h00}; // Reset time.
endpackage

// *** verif/rtcwd_host.sv ***
`timescale 1ns/1ps
module rtcwd_host (
  input wire logic clk_i, // Bus clock.
  input wire logic [7:0] rdata_i, // Data line level.
  output logic cs_b_o, oe_b_o, we_b_o, // Strobes, active low.
  output logic [16:0] addr_o, // Address.
  output logic [7:0] wdata_o // Write data, scrambled when idle.
);
  initial begin
    {cs_b_o, oe_b_o, we_b_o} = 3'h7;
    addr_o = '0;
    wdata_o = 8'h5a;
  end
  // One-cycle write, ended by raising both strobes together.
  task automatic wr(input logic [16:0] a, input logic [7:0] d);
    @(posedge clk_i) #1;
    {cs_b_o, we_b_o, addr_o, wdata_o} = {2'b00, a, d};
    @(posedge clk_i) #1;
    {cs_b_o, we_b_o, wdata_o} = {2'b11, ~d};
    @(posedge clk_i);
  endtask
  // Read held until the answer is taken at the second edge.
  task automatic rd(input logic [16:0] a, output logic [7:0] d);
    @(posedge clk_i) #1;
    {cs_b_o, oe_b_o, addr_o} = {2'b00, a};
    repeat (2) @(posedge clk_i);
    d = rdata_i;
    #1 {cs_b_o, oe_b_o} = 2'b11;
  endtask
endmodule // rtcwd_host

// *** verif/rtcwd_properties.sv ***
`timescale 1ns/1ps
module rtcwd_properties #(
  parameter int PULSE_CYC = 8 // Cycles per interrupt pulse.
) (
  input wire logic clk_i, rst_b_i, chip_sel_b_i, out_drive_b_i, write_strobe_b_i, // Clock, reset, strobes.
  input wire logic [rtcwd_pkg::ADDR_W-1:0] addr_lines_i, // Address.
  input wire logic [7:0] data_lines_i, data_lines_o, // Data both ways.
  input wire logic data_lines_oe_b_o, irq_out_first_o, irq_out_first_oe_b_o, // Data enable, pin A.
  input wire logic irq_out_second_o, irq_out_second_oe_b_o, // Pin B.
  input wire logic square_wave_out_o, square_wave_out_oe_b_o // Square wave.
);
  wire logic wr_w = !chip_sel_b_i && !write_strobe_b_i; // Write active.
  wire logic rd_w = !chip_sel_b_i && !out_drive_b_i && write_strobe_b_i; // Read active.
  logic wa_r; // Write active last cycle.
  logic [rtcwd_pkg::ADDR_W-1:0] ad_r; // Last write address.
  logic [7:0] dt_r, cmd_r; // Last write data and command shadow.
  int pc_r; // Consecutive cycles with pin B drive enable low.
  // Shadow the command byte from completed writes, and time pin B pulses.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wa_r <= 1'b0;
      ad_r <= '0;
      dt_r <= 8'h00;
      cmd_r <= rtcwd_pkg::R_CMD;
      pc_r <= 0;
    end else begin
      wa_r <= wr_w;
      ad_r <= wr_w ? addr_lines_i : ad_r;
      dt_r <= wr_w ? data_lines_i : dt_r;
      cmd_r <= (wa_r && !wr_w && ad_r == 17'h0000b) ? dt_r : cmd_r;
      pc_r <= irq_out_second_oe_b_o ? 0 : pc_r + 1;
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  read_drive_a: assert property (rd_w |=> !data_lines_oe_b_o) else $error("data not driven");
  idle_release_a: assert property (!rd_w |=> data_lines_oe_b_o) else $error("data not released");
  unmapped_zero_a: assert property (rd_w && addr_lines_i > 17'h0000d |=> data_lines_o == 8'h00)
    else $error("unmapped read not zero");
  pin_a_sink_a: assert property (irq_out_first_o == 1'b0) else $error("pin A drives high");
  wave_half_a: assert property (!square_wave_out_oe_b_o && $rose(square_wave_out_o)
    |=> square_wave_out_o [*3] ##1 !square_wave_out_o) else $error("square wave half period");
  pulse_bound_a: assert property (cmd_r[4] |-> pc_r <= PULSE_CYC + 2) else $error("pulse too long");
  b_polarity_a: assert property ($fell(irq_out_second_oe_b_o) |-> irq_out_second_o == cmd_r[5])
    else $error("pin B polarity");
  masked_quiet_a: assert property (cmd_r[3:2] == 2'b11 |=> (irq_out_first_oe_b_o && irq_out_second_oe_b_o))
    else $error("masked interrupt active");
endmodule // rtcwd_properties
bind rtcwd_core rtcwd_properties #(.PULSE_CYC(PULSE_CYC)) rtcwd_properties_i (.*);

// *** verif/tb_rtcwd_core.sv ***
`timescale 1ns/1ps
module tb_rtcwd_core;
  logic clk_i = 1'b0; // Bench clock.
  logic rst_b_i = 1'b0; // Reset, active low.
  logic cs_b, oe_b, we_b, dq_oe_b, ia, ia_oe_b, ib, ib_oe_b, sq, sq_oe_b; // Strobes and pins.
  logic [16:0] ad; // Host address.
  logic [7:0] wd, dout, r; // Host data, device data, read result.
  wire logic [7:0] dq = dq_oe_b ? wd : dout; // The device wins the data lines while it drives.
  int n_mismatch = 0;
  int tests_run = 0;
  int k; // Cycles counted by the last wait.
  initial forever #4 clk_i = ~clk_i;
  rtcwd_core #(.TICK_CYC(20), .WAVE_HALF_CYC(4), .PULSE_CYC(8)) rtcwd_core_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
    .chip_sel_b_i(cs_b), .out_drive_b_i(oe_b), .write_strobe_b_i(we_b), .addr_lines_i(ad), .data_lines_i(dq),
    .data_lines_o(dout), .data_lines_oe_b_o(dq_oe_b), .irq_out_first_o(ia), .irq_out_first_oe_b_o(ia_oe_b),
    .irq_out_second_o(ib), .irq_out_second_oe_b_o(ib_oe_b), .square_wave_out_o(sq), .square_wave_out_oe_b_o(sq_oe_b));
  rtcwd_host rtcwd_host_i (.clk_i(clk_i), .rdata_i(dq), .cs_b_o(cs_b), .oe_b_o(oe_b), .we_b_o(we_b), .addr_o(ad),
    .wdata_o(wd));
  task automatic chk(input string what, input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic w(input logic [16:0] a, input logic [7:0] d); rtcwd_host_i.wr(a, d); endtask
  task automatic rc(input logic [16:0] a, input logic [7:0] e, input string what);
    rtcwd_host_i.rd(a, r);
    chk(what, r, e);
  endtask
  // Wait for pin B (sel set) or pin A to go active, counting cycles.
  task automatic wl(input bit sel, input int lim);
    k = 0;
    while ((sel ? ib_oe_b : ia_oe_b) !== 1'b0 && k < lim) begin
      @(posedge clk_i) #1;
      k++;
    end
  endtask
  task automatic t_regs;
    rc(17'hb, 8'h8c, "cmd reset"); rc(17'h9, 8'hc1, "month reset");
    chk("wave off", {7'h0, sq_oe_b}, 8'h01);
    w(17'h7, 8'hff); rc(17'h7, 8'h87, "alarm day");
    w(17'hb, 8'hff); rc(17'hb, 8'hfc, "cmd flags");
    w(17'h1000e, 8'h77); rc(17'h1000e, 8'h00, "unmapped");
    w(17'hc, 8'h12); w(17'hd, 8'h34); rc(17'hc, 8'h12, "dog c"); rc(17'hd, 8'h34, "dog d");
    $display("regs test done");
  endtask
  task automatic t_dog;
    w(17'h9, 8'h01); w(17'hb, 8'he4); w(17'hd, 8'h00); w(17'hc, 8'h02); // Run, wave on, dog on B, 2 ticks.
    wl(1, 60); chk("dog delay", {7'h0, k >= 20 && k <= 46}, 8'h01);
    chk("wave on", {7'h0, sq_oe_b}, 8'h00);
    repeat (30) @(posedge clk_i); chk("b level", {6'h0, ib_oe_b, ib}, 8'h01);
    rc(17'hb, 8'he6, "dog flag"); rc(17'hd, 8'h00, "dog d");
    repeat (3) @(posedge clk_i); chk("b cleared", {7'h0, ib_oe_b}, 8'h01);
    wl(1, 60); chk("dog again", {7'h0, ib_oe_b}, 8'h00);
    w(17'hc, 8'h00); repeat (200) @(posedge clk_i); chk("dog off", {7'h0, ib_oe_b}, 8'h01);
    $display("dog test done");
  endtask
  task automatic t_pulse;
    w(17'hb, 8'hd4); w(17'hc, 8'h01); wl(1, 30); chk("b sink", {7'h0, ib}, 8'h00);
    wl(0, 0); k = 0;
    while (ib_oe_b === 1'b0 && k < 20) begin @(posedge clk_i) #1; k++; end
    chk("pulse width", {7'h0, k == 8 || k == 9}, 8'h01); rc(17'hb, 8'hd4, "flag pulse");
    wl(1, 30); chk("pulse again", {7'h0, ib_oe_b}, 8'h00); w(17'hc, 8'h00);
    $display("pulse test done");
  endtask
  task automatic t_clock;
    w(17'hb, 8'h08); w(17'h0, 8'h00); w(17'h1, 8'h59); w(17'h2, 8'h59); w(17'h4, 8'h23);
    w(17'h3, 8'h80); w(17'h5, 8'h80); w(17'h7, 8'h80); // Alarm once a minute.
    repeat (60) @(posedge clk_i); rc(17'h0, 8'h00, "frozen");
    w(17'hb, 8'h88); wl(1, 2200); chk("tod alarm", {6'h0, ia_oe_b, ib_oe_b}, 8'h02);
    repeat (25) @(posedge clk_i); rc(17'h2, 8'h00, "min"); rc(17'h4, 8'h00, "hrs");
    rc(17'h6, 8'h02, "day"); rc(17'hb, 8'h89, "tod flag"); rc(17'h3, 8'h80, "alarm min");
    repeat (3) @(posedge clk_i); chk("tod cleared", {7'h0, ib_oe_b}, 8'h01); rc(17'hb, 8'h88, "tod off");
    $display("clock test done");
  endtask
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    #1 rst_b_i = 1'b1;
    t_regs(); t_dog(); t_pulse(); t_clock();
    report_and_stop();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_mismatch++;
    report_and_stop();
  end
endmodule // tb_rtcwd_core
